//--- hdl/wdt_top.sv
// watchdog / interval timer with standby and frequency-change settling
// assumes an APB master, RSTN is the power-on reset, pins are asynchronous
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "wdt_defs.svh"
module wdt_top (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SLEEP_REQ,
  input wire logic NMI_PIN,
  input wire logic IRQ_PIN,
  input wire logic STANDBY_ENABLE_BIT_RST_PIN,
  output logic CLK_RUN,
  output logic INTV_IRQ,
  output logic WDT_POR_REQ,
  output logic WDT_MRST_REQ,
  output logic RESET_OUT_N,
  output logic STATUS_HI
);
  import wdt_pkg::*;

  typedef struct packed {
    wdt_state_t state;
    logic [7:0] cnt;
    logic [7:0] csr;
    logic sby;
    logic [15:0] frq;
    logic follow;
    logic [2:0] nmi_s;
    logic [2:0] irq_s;
    logic [2:0] rst_s;
    logic rst_act;
    logic rst_kind;
    logic [2:0] mrst_cnt;
    logic clk_run;
    logic intv_irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic por_req;
    logic mrst_req;
    logic rst_out_n;
    logic status_hi;
  } wdt_top_st_t;

  wdt_top_st_t st_r;
  wdt_top_st_t st_nxt;
  logic tick;
  logic presc_run;
  logic ovf;
  logic done;
  logic mapped;
  logic key_ok;
  logic [7:0] idx;
  logic [7:0] csr_hw;

  // address decode, shared by read and write paths
  function automatic logic [1:0] reg_sel(input logic [7:0] i);
    case (i)
      `WDT_CNT_IDX: reg_sel = 2'h0;
      `WDT_CSR_IDX: reg_sel = 2'h1;
      `WDT_SBY_IDX: reg_sel = 2'h2;
      default: reg_sel = 2'h3;
    endcase
  endfunction

  assign idx = PADDR[9:2];
  assign mapped = (PADDR[1:0] == 2'h0) && (PADDR[11:10] == 2'h0) &&
                  ((reg_sel(idx) != 2'h3) || (idx == `WDT_FRQ_IDX));
  assign done = PSEL && PENABLE && st_r.pready;

  assign presc_run = (st_r.state == WDT_SBY_CNT) || (st_r.state == WDT_FRQ_CNT) ||
                     (st_r.state == WDT_FRQ_TAIL) || st_r.follow ||
                     ((st_r.state == WDT_RUN) && st_r.csr[`WDT_TME_BIT]);
  assign ovf = tick && (st_r.cnt == 8'hFF);

  wdt_presc u_presc (
    .MCLK(MCLK),
    .RSTN(RSTN),
    .run(presc_run),
    .cks(st_r.csr[2:0]),
    .tick(tick)
  );

  always_comb begin
    st_nxt = st_r;
    key_ok = 1'b0;
    csr_hw = 8'h00;
    st_nxt.nmi_s = {st_r.nmi_s[1:0], NMI_PIN};
    st_nxt.irq_s = {st_r.irq_s[1:0], IRQ_PIN};
    st_nxt.rst_s = {st_r.rst_s[1:0], STANDBY_ENABLE_BIT_RST_PIN};
    st_nxt.pready = PSEL && PENABLE && !st_r.pready;
    st_nxt.pslverr = PSEL && PENABLE && !st_r.pready && !mapped;
    st_nxt.prdata = 32'h0000_0000;
    if (PSEL && PENABLE && !st_r.pready && !PWRITE && mapped) begin
      case (reg_sel(idx))
        2'h0: st_nxt.prdata = {24'h000000, st_r.cnt};
        2'h1: st_nxt.prdata = {24'h000000, st_r.csr};
        2'h2: st_nxt.prdata = {31'h0, st_r.sby};
        default: st_nxt.prdata = {16'h0000, st_r.frq};
      endcase
    end
    if (tick && (st_r.state != WDT_FRQ_TAIL)) begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
    // reset output window
    if (st_r.rst_act) begin
      if (st_r.rst_kind) begin
        st_nxt.mrst_cnt = st_r.mrst_cnt - 3'h1;
        if (st_r.mrst_cnt == 3'h1) begin
          st_nxt.rst_act = 1'b0;
        end
      end else if (tick) begin
        st_nxt.rst_act = 1'b0;
      end
    end
    case (st_r.state)
      WDT_RUN: begin
        if (SLEEP_REQ) begin
          st_nxt.state = WDT_SBY_WAIT;
          st_nxt.clk_run = 1'b0;
          st_nxt.follow = 1'b0;
          st_nxt.cnt = st_r.cnt;
        end else if (st_r.follow) begin
          if (!st_r.sby) begin
            st_nxt.follow = 1'b0;
          end else if (tick && (st_r.cnt == (`WDT_RELOOP_CNT - 8'h01))) begin
            st_nxt.state = WDT_HALT;
            st_nxt.clk_run = 1'b0;
            st_nxt.follow = 1'b0;
          end
        end else if (ovf && st_r.csr[`WDT_TME_BIT]) begin
          if (st_r.csr[`WDT_MODE_BIT]) begin
            st_nxt.csr[`WDT_WATCHDOG_OVERFLOW_FLAG_BIT] = 1'b1;
            st_nxt.rst_act = 1'b1;
            st_nxt.rst_kind = st_r.csr[`WDT_RESET_KIND_SELECT_BIT];
            st_nxt.mrst_cnt = `WDT_MRST_CYC;
          end else begin
            st_nxt.csr[`WDT_INTERVAL_OVERFLOW_FLAG_BIT] = 1'b1;
          end
        end
      end
      WDT_SBY_WAIT: begin
        if (st_r.rst_s[2] && st_r.rst_s[1]) begin
          st_nxt.state = WDT_RUN;
          st_nxt.clk_run = 1'b1;
        end else if ((st_r.nmi_s[2] != st_r.nmi_s[1]) ||
                     (st_r.irq_s[2] && st_r.irq_s[1])) begin
          st_nxt.state = WDT_SBY_CNT;
        end
      end
      WDT_SBY_CNT: begin
        if (ovf) begin
          st_nxt.state = WDT_RUN;
          st_nxt.clk_run = 1'b1;
          st_nxt.follow = 1'b1;
        end
      end
      WDT_FRQ_CNT: begin
        if (ovf) begin
          st_nxt.clk_run = 1'b1;
          st_nxt.state = (st_r.frq[6:4] != 3'h0) ? WDT_FRQ_TAIL : WDT_RUN;
        end
      end
      WDT_FRQ_TAIL: begin
        if (tick) begin
          st_nxt.cnt = 8'h01;
          st_nxt.state = WDT_RUN;
        end
      end
      WDT_HALT: begin
        st_nxt.clk_run = 1'b0;
      end
      default: begin
        st_nxt.state = WDT_RUN;
      end
    endcase
    // control value after hardware flag sets, before the bus write
    csr_hw = st_nxt.csr;
    if (done && PWRITE && mapped) begin
      key_ok = (PSTRB == `WDT_KEY_STRB);
      case (reg_sel(idx))
        2'h0: begin
          if (key_ok && (PWDATA[15:8] == `WDT_CNT_KEY)) begin
            st_nxt.cnt = PWDATA[7:0];
          end
        end
        2'h1: begin
          if (key_ok && (PWDATA[15:8] == `WDT_CSR_KEY)) begin
            st_nxt.csr = PWDATA[7:0];
            // flags: write 1 keeps, write 0 clears, hardware set of a clear flag wins
            st_nxt.csr[`WDT_WATCHDOG_OVERFLOW_FLAG_BIT] = (PWDATA[`WDT_WATCHDOG_OVERFLOW_FLAG_BIT] && st_r.csr[`WDT_WATCHDOG_OVERFLOW_FLAG_BIT]) ||
                                        (csr_hw[`WDT_WATCHDOG_OVERFLOW_FLAG_BIT] && !st_r.csr[`WDT_WATCHDOG_OVERFLOW_FLAG_BIT]);
            st_nxt.csr[`WDT_INTERVAL_OVERFLOW_FLAG_BIT] = (PWDATA[`WDT_INTERVAL_OVERFLOW_FLAG_BIT] && st_r.csr[`WDT_INTERVAL_OVERFLOW_FLAG_BIT]) ||
                                        (csr_hw[`WDT_INTERVAL_OVERFLOW_FLAG_BIT] && !st_r.csr[`WDT_INTERVAL_OVERFLOW_FLAG_BIT]);
          end
        end
        2'h2: begin
          if (PSTRB[0]) begin
            st_nxt.sby = PWDATA[`WDT_SBY_BIT];
          end
        end
        default: begin
          if (key_ok && (st_r.state == WDT_RUN)) begin
            st_nxt.frq = PWDATA[15:0];
            st_nxt.state = WDT_FRQ_CNT;
            st_nxt.clk_run = 1'b0;
            st_nxt.follow = 1'b0;
          end
        end
      endcase
    end
    st_nxt.intv_irq = st_nxt.csr[`WDT_INTERVAL_OVERFLOW_FLAG_BIT];
    st_nxt.por_req = st_nxt.rst_act && !st_nxt.rst_kind;
    st_nxt.mrst_req = st_nxt.rst_act && st_nxt.rst_kind;
    st_nxt.rst_out_n = !st_nxt.rst_act;
    st_nxt.status_hi = st_nxt.rst_act;
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      st_r <= '0;
      st_r.state <= WDT_RUN;
      st_r.cnt <= `WDT_CNT_RST;
      st_r.csr <= `WDT_CSR_RST;
      st_r.frq <= `WDT_FRQ_RST;
      st_r.clk_run <= 1'b1;
      st_r.rst_out_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PRDATA = st_r.prdata;
  assign PREADY = st_r.pready;
  assign PSLVERR = st_r.pslverr;
  assign CLK_RUN = st_r.clk_run;
  assign INTV_IRQ = st_r.intv_irq;
  assign WDT_POR_REQ = st_r.por_req;
  assign WDT_MRST_REQ = st_r.mrst_req;
  assign RESET_OUT_N = st_r.rst_out_n;
  assign STATUS_HI = st_r.status_hi;
endmodule

//--- hdl/wdt_defs.svh
// watchdog / interval timer: register indices, field positions, keys, counts
// assumes APB byte addresses are four times the register index
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

`define WDT_CNT_IDX 8'h84
`define WDT_CSR_IDX 8'h86
`define WDT_SBY_IDX 8'h88
`define WDT_FRQ_IDX 8'h8A
`define WDT_CNT_KEY 8'h5A
`define WDT_CSR_KEY 8'hA5
`define WDT_KEY_STRB 4'h3

`define WDT_TME_BIT 7
`define WDT_MODE_BIT 6
`define WDT_RESET_KIND_SELECT_BIT 5
`define WDT_WATCHDOG_OVERFLOW_FLAG_BIT 4
`define WDT_INTERVAL_OVERFLOW_FLAG_BIT 3
`define WDT_SBY_BIT 0

`define WDT_CNT_RST 8'h00
`define WDT_CSR_RST 8'h00
`define WDT_FRQ_RST 16'h0000
`define WDT_RELOOP_CNT 8'h80
`define WDT_CLK_NS 40
`define WDT_MRST_CYC 3'h5
`define WDT_PRESC_W 12

`endif

//--- hdl/wdt_pkg.sv
// watchdog / interval timer: shared types
// assumes wdt_defs.svh is included by the design files
package wdt_pkg;
  typedef logic [2:0] wdt_cks_t;
  typedef enum logic [2:0] {
    WDT_RUN,
    WDT_SBY_WAIT,
    WDT_SBY_CNT,
    WDT_FRQ_CNT,
    WDT_FRQ_TAIL,
    WDT_HALT
  } wdt_state_t;
  typedef struct packed {
    logic [11:0] cnt;
  } wdt_presc_st_t;
endpackage

//--- hdl/wdt_presc.sv
// watchdog / interval timer: count clock prescaler
// assumes run low restarts the division from zero
`timescale 1ns/100ps
`include "wdt_defs.svh"
module wdt_presc (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic run,
  input wire wdt_pkg::wdt_cks_t cks,
  output logic tick
);
  import wdt_pkg::*;

  wdt_presc_st_t st_r;
  wdt_presc_st_t st_nxt;
  logic [11:0] mask;

  // low-bit mask for each division ratio
  function automatic logic [11:0] div_mask(input wdt_cks_t sel);
    case (sel)
      3'h0: div_mask = 12'h000;
      3'h1: div_mask = 12'h003;
      3'h2: div_mask = 12'h00F;
      3'h3: div_mask = 12'h01F;
      3'h4: div_mask = 12'h03F;
      3'h5: div_mask = 12'h0FF;
      3'h6: div_mask = 12'h3FF;
      default: div_mask = 12'hFFF;
    endcase
  endfunction

  assign mask = div_mask(cks);
  assign tick = run && ((st_r.cnt & mask) == mask);

  always_comb begin
    st_nxt = st_r;
    if (!run) begin
      st_nxt.cnt = 12'h000;
    end else begin
      st_nxt.cnt = st_r.cnt + 12'h001;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

//--- sim/wdt_asserts.sv
// checker: bus answer, reset window, request and clock relations
// assumes it is bound into wdt_top
`timescale 1ns/100ps
module wdt_asserts (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [3:0] PSTRB,
  input wire logic PREADY,
  input wire logic CLK_RUN,
  input wire logic INTV_IRQ,
  input wire logic WDT_POR_REQ,
  input wire logic WDT_MRST_REQ,
  input wire logic RESET_OUT_N,
  input wire logic STATUS_HI
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  sequence s_acc;
    PSEL && !PENABLE ##1 PSEL && PENABLE;
  endsequence
  sequence s_frq;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h228 && PSTRB == 4'h3 && CLK_RUN;
  endsequence
  property p_ans;
    s_acc |-> !PREADY ##1 PREADY;
  endproperty
  property p_mrst;
    $rose(WDT_MRST_REQ) |-> WDT_MRST_REQ [*5] ##1 !WDT_MRST_REQ;
  endproperty
  property p_pin;
    RESET_OUT_N == !(WDT_POR_REQ || WDT_MRST_REQ);
  endproperty
  property p_stat;
    STATUS_HI != RESET_OUT_N;
  endproperty
  property p_kind;
    !(WDT_POR_REQ && WDT_MRST_REQ);
  endproperty
  property p_iv;
    $rose(INTV_IRQ) |-> !WDT_POR_REQ && !WDT_MRST_REQ;
  endproperty
  property p_ivclr;
    $fell(INTV_IRQ) |-> $past(PSEL && PWRITE) || $past(PSEL && PWRITE, 2);
  endproperty
  property p_frq;
    s_frq |-> ##[1:2] !CLK_RUN;
  endproperty
  a_ans: assert property (p_ans) else $error("bus answer not after one wait");
  a_mrst: assert property (p_mrst) else $error("manual window not five");
  a_pin: assert property (p_pin) else $error("reset pin off window");
  a_stat: assert property (p_stat) else $error("status pin wrong");
  a_kind: assert property (p_kind) else $error("two reset kinds");
  a_iv: assert property (p_iv) else $error("interval with reset");
  a_ivclr: assert property (p_ivclr) else $error("request fell alone");
  a_frq: assert property (p_frq) else $error("clock kept after freq write");
endmodule
bind wdt_top wdt_asserts u_chk (.MCLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PSTRB,
  .PREADY, .CLK_RUN, .INTV_IRQ, .WDT_POR_REQ, .WDT_MRST_REQ, .RESET_OUT_N, .STATUS_HI);

//--- sim/tb.sv
// bench: keys, hold, interval, watchdog, frequency and standby runs
// assumes wdt_top alone, with this module as APB master
`timescale 1ns/100ps
`include "wdt_defs.svh"
module tb;
  logic MCLK = 1'b0, RSTN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic [3:0] PSTRB = 4'h0;
  logic SLEEP_REQ = 1'b0, NMI_PIN = 1'b0, IRQ_PIN = 1'b0, STANDBY_ENABLE_BIT_RST_PIN = 1'b0;
  logic PREADY, PSLVERR, CLK_RUN, INTV_IRQ, WDT_POR_REQ, WDT_MRST_REQ, RESET_OUT_N, STATUS_HI;
  int miscompares = 0, compares = 0, n, k;
  integer seed = 32'h7EB4;
  logic [7:0] b;
  logic [32:0] expq[$];
  localparam logic [11:0] A_CNT = 12'h210, A_CSR = 12'h218, A_SBY = 12'h220, A_FRQ = 12'h228;
  wdt_top uut (.MCLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA,
    .PREADY, .PSLVERR, .SLEEP_REQ, .NMI_PIN, .IRQ_PIN, .STANDBY_ENABLE_BIT_RST_PIN, .CLK_RUN,
    .INTV_IRQ, .WDT_POR_REQ, .WDT_MRST_REQ, .RESET_OUT_N, .STATUS_HI);
  always #20 MCLK = ~MCLK;
  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(string nm, logic [32:0] e, logic [32:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [32:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0, 4'h0);
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] key, logic [7:0] d);
    xfer(1'b1, a, {16'h0, key, d}, 4'h3);
  endtask
  task automatic span(logic v);
    n = 0;
    while (RESET_OUT_N === v) begin
      @(posedge MCLK);
      #1;
      n++;
    end
  endtask
  task automatic sleep;
    @(posedge MCLK);
    SLEEP_REQ <= 1'b1;
    @(posedge MCLK);
    SLEEP_REQ <= 1'b0;
    wait (CLK_RUN === 1'b0);
  endtask
  always @(posedge MCLK)
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) cmp("read", expq.pop_front(), {PSLVERR, PRDATA});
  initial begin
    #2000000;
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge MCLK);
    RSTN <= 1'b1;
    rd(A_CNT, 33'h0);
    rd(A_CSR, 33'h0);
    rd(12'h0, 33'h100000000);
    b = 8'($random(seed));
    wr(A_CNT, `WDT_CNT_KEY, b);
    wr(A_CNT, `WDT_CSR_KEY, ~b);
    xfer(1'b1, A_CNT, {16'h0, `WDT_CNT_KEY, ~b}, 4'h1);
    repeat (20) @(posedge MCLK);
    rd(A_CNT, {25'h0, b});
    $display("keys done");
    wr(A_CNT, `WDT_CNT_KEY, 8'hFE);
    wr(A_CSR, `WDT_CSR_KEY, 8'h80);
    wait (INTV_IRQ === 1'b1);
    rd(A_CSR, 33'h88);
    wr(A_CSR, `WDT_CSR_KEY, 8'h80);
    #1;
    cmp("irq clear", 33'h0, INTV_IRQ);
    wait (INTV_IRQ === 1'b1);
    wr(A_CSR, `WDT_CSR_KEY, 8'h00);
    $display("interval done");
    wr(A_CNT, `WDT_CNT_KEY, 8'h00);
    wr(A_CSR, `WDT_CSR_KEY, 8'hC0);
    repeat (3) begin
      repeat (150) @(posedge MCLK);
      wr(A_CNT, `WDT_CNT_KEY, 8'h00);
    end
    rd(A_CSR, 33'hC0);
    cmp("no reset", 33'h1, RESET_OUT_N);
    wr(A_CSR, `WDT_CSR_KEY, 8'h00);
    $display("refresh done");
    for (k = 0; k < 2; k++) begin
      wr(A_CNT, `WDT_CNT_KEY, 8'hF0);
      wr(A_CSR, `WDT_CSR_KEY, k ? 8'hE0 : 8'hC0);
      wait (RESET_OUT_N === 1'b0);
      cmp("reset kind", k ? 33'h6 : 33'h5, {30'h0, STATUS_HI, WDT_MRST_REQ, WDT_POR_REQ});
      span(1'b0);
      cmp("window", k ? 33'h5 : 33'h1, 33'(n));
      rd(A_CSR, k ? 33'hF0 : 33'hD0);
      wr(A_CSR, `WDT_CSR_KEY, 8'h00);
    end
    $display("watchdog done");
    for (k = 0; k < 2; k++) begin
      xfer(1'b1, A_FRQ, {16'h0, 9'h0, 3'(k), 1'b0, 3'(k + 1)}, 4'h3);
      wait (CLK_RUN === 1'b0);
      wait (CLK_RUN === 1'b1);
      repeat (4) @(posedge MCLK);
      rd(A_CNT, 33'(k));
    end
    $display("frequency done");
    wr(A_CNT, `WDT_CNT_KEY, 8'h00);
    xfer(1'b1, A_SBY, 32'h1, 4'h1);
    sleep;
    @(posedge MCLK);
    STANDBY_ENABLE_BIT_RST_PIN <= 1'b1;
    wait (CLK_RUN === 1'b1);
    @(posedge MCLK);
    STANDBY_ENABLE_BIT_RST_PIN <= 1'b0;
    repeat (20) @(posedge MCLK);
    rd(A_CNT, 33'h0);
    sleep;
    repeat (300) @(posedge MCLK);
    cmp("clock idle", 33'h0, CLK_RUN);
    NMI_PIN <= 1'b1;
    wait (CLK_RUN === 1'b1);
    rd(A_CSR, 33'h0);
    wait (CLK_RUN === 1'b0);
    rd(A_CNT, 33'h80);
    RSTN <= 1'b0;
    repeat (4) @(posedge MCLK);
    RSTN <= 1'b1;
    rd(A_SBY, 33'h0);
    cmp("clock back", 33'h1, CLK_RUN);
    $display("standby done");
    finish_test;
  end
endmodule
